// ===== design/trcd_top.sv
// Purpose: decode five terminal inputs into run, direction, jog and stop commands
// Assumes: terminal inputs synchronous-ish, sampled twice; APB slave for settings
// Notes: reversal interval counted in 1 ms ticks; two-line modes leave run off
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/100ps
module trcd_top #(
   parameter int TICK_CYCLES = trcd_pkg::TICK_CYC
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic clk_en,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // terminals
   input wire logic [4:0] term_in,
   // commands to motor control
   output logic run_cmd,
   output logic rotation_direction,
   output logic jog_forward_command,
   output logic jog_reverse_command,
   output logic coast_stop,
   output logic run_pause
);
   // run states shared with the package, declared before the state struct uses them
   typedef trcd_pkg::trcd_run_t trcd_run_t;
   // whole module state
   typedef struct packed {
      logic [2:0] mode;
      logic [4:0][5:0] func;
      logic [15:0] revint;
      logic [4:0] s1;
      logic [4:0] s2;
      logic [4:0] s3;
      trcd_run_t run;
      logic dir;
      logic [31:0] tick;
      logic [15:0] ms;
      logic [31:0] rdata;
      logic rdy;
      logic err;
      logic o_run;
      logic o_dir;
      logic o_jf;
      logic o_jr;
      logic o_co;
      logic o_pa;
   } trcd_st_t;

   // registered state and its next value
   trcd_st_t q;
   trcd_st_t d;

   // per-function combined levels and edges
   logic fwd_lvl, rev_lvl, hold_lvl, jf_lvl, jr_lvl, co_lvl, pa_lvl;
   logic fwd_edge, rev_edge;
   logic [4:0] rise;
   logic apb_acc;
   logic map_hit;
   logic [31:0] rd_val;
   logic tick_hit;

   // next state
   always_comb begin
      d = q;
      // first, second and third stage of the input samplers
      d.s1 = term_in;
      d.s2 = q.s1;
      d.s3 = q.s2;
      rise = q.s2 & ~q.s3;
      // gather functions; code zero or unknown contributes nothing
      fwd_lvl = 1'b0;
      rev_lvl = 1'b0;
      hold_lvl = 1'b0;
      jf_lvl = 1'b0;
      jr_lvl = 1'b0;
      co_lvl = 1'b0;
      pa_lvl = 1'b0;
      fwd_edge = 1'b0;
      rev_edge = 1'b0;
      for (int i = 0; i < 5; i++) begin
         case (q.func[i])
            trcd_pkg::FN_FWD: begin
               fwd_lvl = fwd_lvl | q.s2[i];
               fwd_edge = fwd_edge | rise[i];
            end
            trcd_pkg::FN_REV: begin
               rev_lvl = rev_lvl | q.s2[i];
               rev_edge = rev_edge | rise[i];
            end
            trcd_pkg::FN_HOLD: hold_lvl = hold_lvl | q.s2[i];
            trcd_pkg::FN_JOGF: jf_lvl = jf_lvl | q.s2[i];
            trcd_pkg::FN_JOGR: jr_lvl = jr_lvl | q.s2[i];
            trcd_pkg::FN_COAST: co_lvl = co_lvl | q.s2[i];
            trcd_pkg::FN_PAUSE: pa_lvl = pa_lvl | q.s2[i];
            default: ;
         endcase
      end
      // millisecond tick for the reversal interval
      tick_hit = (q.tick == 32'(TICK_CYCLES - 1));
      d.tick = tick_hit ? 32'h0 : q.tick + 32'h1;
      if (tick_hit && q.ms != 16'hffff) begin
         d.ms = q.ms + 16'h1;
      end
      // run sequencing per mode
      case (q.mode)
         trcd_pkg::MD_3L1: begin
            if (!hold_lvl) begin
               d.run = trcd_pkg::RS_IDLE;
            end else if (fwd_edge) begin
               d.run = trcd_pkg::RS_RUN;
               d.dir = 1'b0;
            end else if (rev_edge) begin
               d.run = trcd_pkg::RS_RUN;
               d.dir = 1'b1;
            end
         end
         trcd_pkg::MD_3L2: begin
            if (!hold_lvl) begin
               d.run = trcd_pkg::RS_IDLE;
            end else begin
               if (fwd_edge) begin
                  d.run = trcd_pkg::RS_RUN;
               end
               d.dir = rev_lvl;
            end
         end
         trcd_pkg::MD_ALT: begin
            if (!hold_lvl) begin
               d.run = trcd_pkg::RS_IDLE;
            end else if (fwd_edge | rev_edge) begin
               if (q.run == trcd_pkg::RS_RUN) begin
                  d.run = trcd_pkg::RS_IDLE;
               end else begin
                  d.run = trcd_pkg::RS_RUN;
                  d.dir = rev_edge & ~fwd_edge;
               end
            end
         end
         trcd_pkg::MD_BAF: begin
            if (!hold_lvl) begin
               d.run = trcd_pkg::RS_IDLE; // direction remembered
            end else if (q.run != trcd_pkg::RS_RUN) begin
               d.run = trcd_pkg::RS_RUN;
               d.ms = 16'h0;
               d.tick = 32'h0;
            end else if ((fwd_edge | rev_edge) && q.ms >= q.revint) begin
               d.dir = ~q.dir;
               d.ms = 16'h0;
               d.tick = 32'h0;
            end
         end
         default: d.run = trcd_pkg::RS_IDLE;
      endcase
      // registered command outputs
      d.o_co = co_lvl;
      d.o_pa = pa_lvl;
      d.o_run = (d.run == trcd_pkg::RS_RUN) & ~co_lvl & ~pa_lvl;
      d.o_dir = d.dir;
      d.o_jf = jf_lvl & ~co_lvl;
      d.o_jr = jr_lvl & ~co_lvl & ~jf_lvl;
      // apb slave, one wait state per access, pready registered
      apb_acc = psel & penable & ~q.rdy;
      map_hit = 1'b1;
      rd_val = 32'h0;
      case (paddr)
         trcd_pkg::OFS_MODE: rd_val = {29'h0, q.mode};
         trcd_pkg::OFS_FUNC1: rd_val = {26'h0, q.func[0]};
         trcd_pkg::OFS_FUNC2: rd_val = {26'h0, q.func[1]};
         trcd_pkg::OFS_FUNC3: rd_val = {26'h0, q.func[2]};
         trcd_pkg::OFS_FUNC4: rd_val = {26'h0, q.func[3]};
         trcd_pkg::OFS_FUNC5: rd_val = {26'h0, q.func[4]};
         trcd_pkg::OFS_REVINT: rd_val = {16'h0, q.revint};
         trcd_pkg::OFS_STATUS: begin
            rd_val[trcd_pkg::ST_RUN] = q.o_run;
            rd_val[trcd_pkg::ST_DIR] = q.o_dir;
            rd_val[trcd_pkg::ST_JOGF] = q.o_jf;
            rd_val[trcd_pkg::ST_JOGR] = q.o_jr;
            rd_val[trcd_pkg::ST_COAST] = q.o_co;
            rd_val[trcd_pkg::ST_PAUSE] = q.o_pa;
            rd_val[trcd_pkg::ST_IN +: 5] = q.s2;
         end
         default: map_hit = 1'b0;
      endcase
      d.rdy = apb_acc;
      d.err = 1'b0;
      d.rdata = 32'h0;
      if (apb_acc) begin
         d.rdata = pwrite ? 32'h0 : rd_val;
         d.err = ~map_hit;
         if (pwrite) begin
            case (paddr)
               trcd_pkg::OFS_MODE: begin
                  if (pwdata[2:0] <= trcd_pkg::MD_BAF) begin
                     d.mode = pwdata[2:0];
                  end else begin
                     d.err = 1'b1;
                  end
               end
               trcd_pkg::OFS_REVINT: d.revint = pwdata[15:0];
               trcd_pkg::OFS_STATUS: d.err = 1'b1;
               default: begin
                  for (int i = 0; i < 5; i++) begin
                     if (paddr == trcd_pkg::OFS_FUNC1 + 8'(4 * i)) begin
                        if (pwdata[5:0] <= trcd_pkg::FUNC_MAX) begin
                           d.func[i] = pwdata[5:0];
                        end else begin
                           d.err = 1'b1;
                        end
                     end
                  end
               end
            endcase
         end
      end
   end

   // state register
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
         q.mode <= trcd_pkg::MODE_RST;
         q.func <= {trcd_pkg::FUNC5_RST, trcd_pkg::FUNC4_RST, trcd_pkg::FUNC3_RST,
                    trcd_pkg::FUNC2_RST, trcd_pkg::FUNC1_RST};
         q.revint <= trcd_pkg::REVINT_RST;
         q.run <= trcd_pkg::RS_IDLE;
      end else if (clk_en) begin
         q <= d;
      end
   end

   // outputs straight from flip-flops
   assign prdata = q.rdata;
   assign pready = q.rdy;
   assign pslverr = q.err;
   assign run_cmd = q.o_run;
   assign rotation_direction = q.o_dir;
   assign jog_forward_command = q.o_jf;
   assign jog_reverse_command = q.o_jr;
   assign coast_stop = q.o_co;
   assign run_pause = q.o_pa;

   // hold open in three-line mode 1 stops the motor at the next edge
   a_hold_stops: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (clk_en && q.mode == trcd_pkg::MD_3L1 && !hold_lvl) |=> !q.o_run)
      else $error("run kept while hold open");
   // coast stop forces run off next cycle
   a_coast_block: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (clk_en && co_lvl) |=> (!q.o_run && !q.o_jf && !q.o_jr))
      else $error("output not blocked by coast stop");
   // edge detect is single cycle
   a_edge_single: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (clk_en && rise[0]) |=> !(clk_en && rise[0]))
      else $error("edge lasted two cycles");
   // three-line 2 direction follows direction input
   a_dir_level: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (clk_en && q.mode == trcd_pkg::MD_3L2 && hold_lvl) |=> q.dir == $past(rev_lvl))
      else $error("direction not from level");
   // alternate stop edge stops the motor
   a_alt_stop: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (clk_en && q.mode == trcd_pkg::MD_ALT && q.run == trcd_pkg::RS_RUN
       && (fwd_edge || rev_edge)) |=> q.run == trcd_pkg::RS_IDLE)
      else $error("alternate edge did not stop");
   // reversal respects minimum interval
   a_rev_interval: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (clk_en && q.mode == trcd_pkg::MD_BAF && q.run == trcd_pkg::RS_RUN
       && q.ms < q.revint) |=> q.dir == $past(q.dir))
      else $error("reversal before interval");
   // first function code above range never stored
   a_func_range: assert property (@(posedge ref_clk) disable iff (!arst_n)
      q.func[0] <= trcd_pkg::FUNC_MAX)
      else $error("function code out of range");
   // pause drops run while kept
   a_pause_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (clk_en && pa_lvl) |=> (!q.o_run && q.run == $past(d.run)))
      else $error("pause did not hold");
   // hold open in three-line mode 2 stops the motor as well
   a_hold_stops_two: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (clk_en && q.mode == trcd_pkg::MD_3L2 && !hold_lvl) |=> !q.o_run)
      else $error("run kept while hold open in mode two");
   // in three-line mode 1 a forward edge with hold closed starts forward rotation
   a_fwd_start: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (clk_en && q.mode == trcd_pkg::MD_3L1 && hold_lvl && fwd_edge)
      |=> (q.run == trcd_pkg::RS_RUN && !q.dir))
      else $error("forward edge did not start forward run");
   // without a run edge three-line 2 never leaves the stopped state
   a_run_edge_only: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (clk_en && q.mode == trcd_pkg::MD_3L2 && q.run != trcd_pkg::RS_RUN && !fwd_edge)
      |=> q.run != trcd_pkg::RS_RUN)
      else $error("run began without a run edge");
   // alternate start edge runs in the direction of its own input
   a_alt_start: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (clk_en && q.mode == trcd_pkg::MD_ALT && hold_lvl && q.run != trcd_pkg::RS_RUN
       && (fwd_edge || rev_edge))
      |=> (q.run == trcd_pkg::RS_RUN && q.dir == $past(!fwd_edge)))
      else $error("alternate start edge gave wrong run or direction");
   // hold open in alternate mode stops wherever the sequence stands
   a_alt_hold_open: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (clk_en && q.mode == trcd_pkg::MD_ALT && !hold_lvl) |=> !q.o_run)
      else $error("alternate run kept while hold open");
   // back-and-forth runs whenever hold is closed
   a_baf_hold_run: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (clk_en && q.mode == trcd_pkg::MD_BAF && hold_lvl) |=> q.run == trcd_pkg::RS_RUN)
      else $error("back-and-forth not running with hold closed");
   // an edge after the minimum interval reverses the direction
   a_rev_flip: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (clk_en && q.mode == trcd_pkg::MD_BAF && q.run == trcd_pkg::RS_RUN && hold_lvl
       && (fwd_edge || rev_edge) && q.ms >= q.revint) |=> q.dir != $past(q.dir))
      else $error("reversal edge ignored after interval");
   // fifth function select never holds a code above range
   a_func5_range: assert property (@(posedge ref_clk) disable iff (!arst_n)
      q.func[4] <= trcd_pkg::FUNC_MAX)
      else $error("fifth function code out of range");
   // the unused two-line codes never run the motor
   a_two_line_off: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (clk_en && q.mode <= trcd_pkg::MD_2L2) |=> !q.o_run)
      else $error("run issued in a two-line mode");
   // mode register never holds an undefined code
   a_mode_range: assert property (@(posedge ref_clk) disable iff (!arst_n)
      q.mode <= trcd_pkg::MD_BAF)
      else $error("mode code out of range");
   // coast stop output follows its input one enabled edge later
   a_coast_follow: assert property (@(posedge ref_clk) disable iff (!arst_n)
      clk_en |=> q.o_co == $past(co_lvl))
      else $error("coast stop output lags its input");
   // forward jog follows its input unless coast stop blocks it
   a_jog_follow: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (clk_en && jf_lvl && !co_lvl) |=> q.o_jf)
      else $error("forward jog not issued");
   // reverse jog follows its input when neither coast nor forward jog is set
   a_jog_rev_follow: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (clk_en && jr_lvl && !jf_lvl && !co_lvl) |=> q.o_jr)
      else $error("reverse jog not issued");
   // pause output follows its input one enabled edge later
   a_pause_follow: assert property (@(posedge ref_clk) disable iff (!arst_n)
      clk_en |=> q.o_pa == $past(pa_lvl))
      else $error("pause output lags its input");
endmodule

// ===== design/trcd_pkg.sv
// Purpose: constants and types for the terminal run command decoder
// Assumes: 100 MHz ref_clk, APB register access with 32-bit data
// Notes: register offsets are byte addresses of aligned words
package trcd_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_FUNC1 = 8'h04;
   localparam logic [7:0] OFS_FUNC2 = 8'h08;
   localparam logic [7:0] OFS_FUNC3 = 8'h0c;
   localparam logic [7:0] OFS_FUNC4 = 8'h10;
   localparam logic [7:0] OFS_FUNC5 = 8'h14;
   localparam logic [7:0] OFS_REVINT = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h1c;
   // reset values
   localparam logic [2:0] MODE_RST = 3'h0;
   localparam logic [5:0] FUNC1_RST = 6'h01;
   localparam logic [5:0] FUNC2_RST = 6'h02;
   localparam logic [5:0] FUNC3_RST = 6'h04;
   localparam logic [5:0] FUNC4_RST = 6'h06;
   localparam logic [5:0] FUNC5_RST = 6'h08;
   localparam logic [15:0] REVINT_RST = 16'h000a;
   // function code range limit
   localparam logic [5:0] FUNC_MAX = 6'h35;
   // function codes
   localparam logic [5:0] FN_NONE = 6'h00;
   localparam logic [5:0] FN_FWD = 6'h01;
   localparam logic [5:0] FN_REV = 6'h02;
   localparam logic [5:0] FN_HOLD = 6'h03;
   localparam logic [5:0] FN_JOGF = 6'h04;
   localparam logic [5:0] FN_JOGR = 6'h05;
   localparam logic [5:0] FN_COAST = 6'h06;
   localparam logic [5:0] FN_PAUSE = 6'h07;
   // command mode codes
   localparam logic [2:0] MD_2L1 = 3'h0;
   localparam logic [2:0] MD_2L2 = 3'h1;
   localparam logic [2:0] MD_3L1 = 3'h2;
   localparam logic [2:0] MD_3L2 = 3'h3;
   localparam logic [2:0] MD_ALT = 3'h4;
   localparam logic [2:0] MD_BAF = 3'h5;
   // reversal interval unit: 1 ms in cycles of the 100 MHz clock
   localparam int CLK_MHZ = 100;
   localparam int TICK_US = 1000;
   localparam int TICK_CYC = TICK_US * CLK_MHZ;
   // status field positions
   localparam int ST_RUN = 0;
   localparam int ST_DIR = 1;
   localparam int ST_JOGF = 2;
   localparam int ST_JOGR = 3;
   localparam int ST_COAST = 4;
   localparam int ST_PAUSE = 5;
   localparam int ST_IN = 8;
   // run state machine, one-hot
   typedef enum logic [2:0] {
      RS_IDLE = 3'b001,
      RS_RUN = 3'b010,
      RS_WAIT = 3'b100
   } trcd_run_t;
endpackage

// ===== verif/trcd_switches.sv
// Purpose: push buttons and switches wired to the five terminal inputs
// Assumes: the bench sets the wanted contact states just after a clock edge
// Notes: an open contact reads low, so a released line never shows a stale level
`timescale 1ns/100ps
module trcd_switches (
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // contact states wanted by the operator
   input wire logic [4:0] press,
   // contacts seen by the terminals
   output logic [4:0] term_in
);
   // contacts settle one edge after the operator acts
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         term_in <= 5'h00; // all contacts open
      end else begin
         term_in <= press;
      end
   end
endmodule

// ===== verif/test_trcd_top.sv
// Purpose: self-checking bench for the terminal run command decoder
// Assumes: one ms tick shortened to 4 cycles, clk_en high except in t_freeze
// Notes: bit 0 forward, bit 1 reverse, bit 2 hold once set up
`timescale 1ns/100ps
module test_trcd_top;
   logic ref_clk = 1'b0; // 100 MHz
   logic arst_n = 1'b0; // reset, active low
   logic clk_en = 1'b1; // low only in t_freeze
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [4:0] press = 5'h00; // wanted contacts
   logic [4:0] term_in;
   logic run_cmd, rotation_direction, jog_forward_command;
   logic jog_reverse_command, coast_stop, run_pause;
   logic [5:0] outs; // command outputs in status bit order
   logic [31:0] rd; // last read data
   logic err; // last slave error
   int n_fail = 0;
   int checks = 0;
   assign outs = {run_pause, coast_stop, jog_reverse_command, jog_forward_command,
                  rotation_direction, run_cmd};
   // design under test with a short ms tick
   trcd_top #(.TICK_CYCLES(4)) DUT (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .term_in(term_in),
      .run_cmd(run_cmd), .rotation_direction(rotation_direction),
      .jog_forward_command(jog_forward_command), .jog_reverse_command(jog_reverse_command),
      .coast_stop(coast_stop), .run_pause(run_pause));
   // operator at the terminals
   trcd_switches sw (.ref_clk(ref_clk), .arst_n(arst_n), .press(press), .term_in(term_in));
   // clock
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end
   task tally_and_finish;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one apb transfer, held until pready is seen at an edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d, input logic e);
      apb(1'b1, a, d);
      chk("slave error", {31'h0, e}, {31'h0, err});
   endtask
   task setfn(input logic [7:0] a, input logic [5:0] f);
      wr(a, {26'h0, f}, 1'b0);
   endtask
   task setmode(input logic [2:0] m);
      wr(trcd_pkg::OFS_MODE, {29'h0, m}, 1'b0);
   endtask
   task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask
   // contacts change, then the synchroniser and decoder settle
   task setp(input logic [4:0] v);
      press <= v;
      repeat (8) @(posedge ref_clk);
   endtask
   task pulse(input int b);
      setp(press | 5'(1 << b));
      setp(press & ~5'(1 << b));
   endtask
   task co(input logic [5:0] e);
      chk("outputs", {26'h0, e}, {26'h0, outs});
   endtask
   task cr(input logic e);
      chk("run_cmd", {31'h0, e}, {31'h0, run_cmd});
   endtask
   // reset values, code limits and refused writes
   task t_regs;
      rchk("mode", trcd_pkg::OFS_MODE, 32'h0);
      rchk("func1", trcd_pkg::OFS_FUNC1, 32'h1);
      rchk("func5", trcd_pkg::OFS_FUNC5, 32'h8);
      wr(trcd_pkg::OFS_FUNC2, 32'h35, 1'b0);
      wr(trcd_pkg::OFS_FUNC2, 32'h36, 1'b1);
      rchk("func2", trcd_pkg::OFS_FUNC2, 32'h35);
      wr(trcd_pkg::OFS_MODE, 32'h6, 1'b1);
      wr(trcd_pkg::OFS_STATUS, 32'h0, 1'b1);
      wr(8'h40, 32'h0, 1'b1);
      setfn(trcd_pkg::OFS_FUNC2, trcd_pkg::FN_REV);
      setfn(trcd_pkg::OFS_FUNC3, trcd_pkg::FN_HOLD);
   endtask
   // three-line 1: edges start, hold level stops
   task t_three1;
      setmode(trcd_pkg::MD_3L1);
      pulse(0);
      setp(5'h04);
      cr(1'b0);
      pulse(0);
      co(6'h01);
      pulse(1);
      co(6'h03);
      setp(5'h00);
      pulse(0);
      setp(5'h04);
      cr(1'b0);
      setp(5'h00);
   endtask
   // three-line 2: run edge, direction by level
   task t_three2;
      setmode(trcd_pkg::MD_3L2);
      setp(5'h06);
      cr(1'b0);
      pulse(0);
      co(6'h03);
      setp(5'h04);
      co(6'h01);
      setp(5'h00);
      cr(1'b0);
      setmode(trcd_pkg::MD_2L2);
      setp(5'h05);
      cr(1'b0);
      setp(5'h00);
   endtask
   // reset with the motor stopped: outputs clear at once, settings return to reset values
   task t_reset;
      arst_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      co(6'h00);
      arst_n <= 1'b1;
      @(posedge ref_clk);
      rchk("mode", trcd_pkg::OFS_MODE, {29'h0, trcd_pkg::MODE_RST});
      rchk("func3", trcd_pkg::OFS_FUNC3, {26'h0, trcd_pkg::FUNC3_RST});
      setfn(trcd_pkg::OFS_FUNC3, trcd_pkg::FN_HOLD);
   endtask
   // alternate: start, stop from the reverse input, restart sets direction
   task t_alt;
      setmode(trcd_pkg::MD_ALT);
      setp(5'h04);
      setp(5'h05);
      setp(5'h05);
      co(6'h01);
      setp(5'h04);
      pulse(1);
      cr(1'b0);
      pulse(1);
      co(6'h03);
      setp(5'h00);
      cr(1'b0);
   endtask
   // back-and-forth: 8 ms minimum between reversals
   task t_baf;
      wr(trcd_pkg::OFS_REVINT, 32'h8, 1'b0);
      setmode(trcd_pkg::MD_BAF);
      setp(5'h04);
      co(6'h01);
      repeat (40) @(posedge ref_clk);
      pulse(0);
      co(6'h03);
      pulse(1);
      co(6'h03);
      setp(5'h00);
      cr(1'b0);
      setp(5'h04);
      co(6'h03);
      repeat (40) @(posedge ref_clk);
      pulse(1);
      co(6'h01);
      setp(5'h00);
   endtask
   // function codes: none, forward, pause, coast, both jogs
   task t_funcs;
      setmode(trcd_pkg::MD_3L1);
      setfn(trcd_pkg::OFS_FUNC1, trcd_pkg::FN_NONE);
      setp(5'h04);
      pulse(0);
      cr(1'b0);
      setfn(trcd_pkg::OFS_FUNC1, trcd_pkg::FN_FWD);
      pulse(0);
      co(6'h01);
      rchk("status", trcd_pkg::OFS_STATUS, 32'h401);
      setfn(trcd_pkg::OFS_FUNC4, trcd_pkg::FN_PAUSE);
      setp(5'h0c);
      co(6'h20);
      setp(5'h04);
      co(6'h01);
      setfn(trcd_pkg::OFS_FUNC4, trcd_pkg::FN_COAST);
      setp(5'h0c);
      co(6'h10);
      setp(5'h00);
      setfn(trcd_pkg::OFS_FUNC5, trcd_pkg::FN_JOGF);
      setp(5'h10);
      chk("jog", 32'h1, {30'h0, jog_reverse_command, jog_forward_command});
      setfn(trcd_pkg::OFS_FUNC5, trcd_pkg::FN_JOGR);
      setp(5'h10);
      chk("jog", 32'h2, {30'h0, jog_reverse_command, jog_forward_command});
      setp(5'h00);
   endtask
   // clock enable low freezes the outputs while the contacts change
   task t_freeze;
      setp(5'h10);
      clk_en <= 1'b0;
      setp(5'h00);
      chk("jog frozen", 32'h2, {30'h0, jog_reverse_command, jog_forward_command});
      clk_en <= 1'b1;
      setp(5'h00);
      chk("jog released", 32'h0, {30'h0, jog_reverse_command, jog_forward_command});
   endtask
   // hang guard, far beyond the expected run length
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_fail++;
      tally_and_finish;
   end
   // main sequence
   initial begin
      repeat (3) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(posedge ref_clk);
      t_regs;
      t_three1;
      t_three2;
      t_alt;
      t_reset;
      t_baf;
      t_funcs;
      t_freeze;
      tally_and_finish;
   end
endmodule
